// [hdl/tsl_trigger_sync.sv]
/*
  tsl_trigger_sync: per-object trigger line logic with an AXI4-Lite register
  slave, trigger bus input sync, pulse/toggle output, timestamp frames,
  transmit-on-edge write queue and timebase routing.
  assumes: aclk is the master timebase; tx_ready_i, tx_done_i and rx_stored_i
  come from the frame engine on aclk; trigger pins, star trigger and slot
  strap come from outside and are synchronised here.
*/
`timescale 1ns/1ps
module tsl_trigger_sync
    import tsl_pkg::*;
#(
    parameter int WQ_MAX = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // trigger bus pins, line 7 is the clock line
    input wire logic [7:0] trig_i,
    output logic [6:0] trig_o,
    output logic [6:0] trig_oe_n,
    input wire logic star_trig_i,
    input wire logic [4:0] slot_i,
    // timebase routing
    output logic [1:0] timebase_sel_o,
    output logic osc_export_o,
    // frame engine side
    output logic tx_valid_o,
    output logic [31:0] tx_data_o,
    input wire logic tx_ready_i,
    input wire logic tx_done_i,
    input wire logic rx_stored_i,
    output logic rx_valid_o,
    output logic [31:0] rx_ts_o,
    output logic [31:0] rx_data_o
);
    localparam int AW = $clog2(WQ_MAX);

    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic star1;
        logic star2;
        logic [4:0] slot1;
        logic [4:0] slot2;
        logic src_prev;
        tsl_mode_t mode;
        logic toggle;
        logic gen1;
        logic [2:0] line;
        logic [7:0] skip;
        logic [4:0] wqlen;
        logic [31:0] tag;
        tsl_tb_t tb;
        logic export_osc;
        logic star_sel;
        logic [7:0] skip_cnt;
        tsl_out_st_t out_st;
        logic [11:0] pulse_cnt;
        logic out_lvl;
        logic [WQ_MAX-1:0][31:0] wq_mem;
        logic [AW-1:0] wq_rd;
        logic [AW-1:0] wq_wr;
        logic [AW:0] wq_cnt;
        logic [31:0] last;
        logic have_last;
        logic ovf;
        logic [31:0] tstamp;
        logic tx_valid;
        logic [31:0] tx_data;
        logic rx_valid;
        logic [31:0] rx_ts;
        logic [31:0] rx_data;
        logic [6:0] trig;
        logic [6:0] trig_oe_n;
        logic awready;
        logic wready;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tsl_state_t;

    tsl_state_t s_q;
    tsl_state_t s_d;

    // byte-lane merge for stored registers
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic is_out_mode(input tsl_mode_t m);
        return (m == OUTPUT_ON_COMMAND) || (m == OUTPUT_ON_RECEIVE) || (m == OUTPUT_ON_TRANSMIT);
    endfunction

    function automatic logic is_in_mode(input tsl_mode_t m);
        return (m == TIMESTAMP_ON_INPUT) || (m == TRANSMIT_ON_INPUT);
    endfunction

    logic star_ok;
    logic src;
    logic rise;
    logic act;
    logic out_ev;
    logic push;
    logic action;
    logic [31:0] ctrl_img;
    logic [31:0] route_img;
    logic [31:0] wr_val;

    always_comb begin
        star_ok = (s_q.slot2 >= STAR_MIN_SLOT);
        src = (s_q.star_sel && star_ok) ? s_q.star2 : s_q.sync2[s_q.line];
        rise = src && !s_q.src_prev;
        // >= so that lowering the skip count mid-run never strands the counter above it
        act = rise && is_in_mode(s_q.mode) && (s_q.skip_cnt >= s_q.skip);
        ctrl_img = '0;
        ctrl_img[CTRL_MODE_LSB +: 3] = s_q.mode;
        ctrl_img[CTRL_BEHAV_BIT] = s_q.toggle;
        ctrl_img[CTRL_GEN1_BIT] = s_q.gen1;
        ctrl_img[CTRL_LINE_LSB +: 3] = s_q.line;
        ctrl_img[CTRL_SKIP_LSB +: 8] = s_q.skip;
        ctrl_img[CTRL_WQLEN_LSB +: 5] = s_q.wqlen;
        route_img = '0;
        route_img[ROUTE_TB_LSB +: 2] = s_q.tb;
        route_img[ROUTE_EXPORT_BIT] = s_q.export_osc;
        route_img[ROUTE_STAR_BIT] = s_q.star_sel;
    end

    always_comb begin
        s_d = s_q;
        push = 1'b0;
        action = 1'b0;
        wr_val = '0;
        // two-stage input synchronisers
        s_d.sync1 = trig_i;
        s_d.sync2 = s_q.sync1;
        s_d.star1 = star_trig_i;
        s_d.star2 = s_q.star1;
        s_d.slot1 = slot_i;
        s_d.slot2 = s_q.slot1;
        s_d.src_prev = src;
        s_d.tstamp = s_q.tstamp + 32'h0000_0001;

        // AXI write channel: address and data in either order
        if (s_axi_awvalid && s_q.awready) begin
            s_d.awaddr = s_axi_awaddr;
            s_d.awready = 1'b0;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
            s_d.wready = 1'b0;
        end
        if (!s_q.awready && !s_q.wready && !s_q.bvalid) begin
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            case (s_q.awaddr)
                ADDR_CTRL: begin
                    wr_val = lane_merge(ctrl_img, s_q.wdata, s_q.wstrb);
                    s_d.mode = tsl_mode_t'(wr_val[CTRL_MODE_LSB +: 3]);
                    s_d.toggle = wr_val[CTRL_BEHAV_BIT];
                    s_d.gen1 = wr_val[CTRL_GEN1_BIT];
                    if (wr_val[CTRL_LINE_LSB +: 3] <= LINE_MAX) begin
                        s_d.line = wr_val[CTRL_LINE_LSB +: 3];
                    end
                    s_d.skip = wr_val[CTRL_SKIP_LSB +: 8];
                    s_d.wqlen = (wr_val[CTRL_WQLEN_LSB +: 5] > 5'(WQ_MAX)) ? 5'(WQ_MAX)
                                                                          : wr_val[CTRL_WQLEN_LSB +: 5];
                end
                ADDR_TAG: begin
                    s_d.tag = lane_merge(s_q.tag, s_q.wdata, s_q.wstrb);
                end
                ADDR_ROUTE: begin
                    wr_val = lane_merge(route_img, s_q.wdata, s_q.wstrb);
                    s_d.tb = (wr_val[ROUTE_TB_LSB +: 2] == 2'h3) ? s_q.tb : tsl_tb_t'(wr_val[ROUTE_TB_LSB +: 2]);
                    s_d.export_osc = wr_val[ROUTE_EXPORT_BIT];
                    s_d.star_sel = wr_val[ROUTE_STAR_BIT];
                end
                ADDR_CMD: begin
                    action = s_q.wdata[CMD_ACTION_BIT];
                    if (s_q.wdata[CMD_CLR_OVF_BIT]) begin
                        s_d.ovf = 1'b0;
                    end
                end
                ADDR_TXDATA: begin
                    push = 1'b1;
                end
                ADDR_STATUS, ADDR_TSTAMP: begin
                    s_d.bresp = RESP_OKAY;
                end
                default: begin
                    s_d.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready = 1'b1;
        end

        // AXI read channel
        if (s_axi_arvalid && s_q.arready) begin
            s_d.arready = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL: s_d.rdata = ctrl_img;
                ADDR_TAG: s_d.rdata = s_q.tag;
                ADDR_ROUTE: s_d.rdata = route_img;
                ADDR_STATUS: begin
                    s_d.rdata = '0;
                    s_d.rdata[AW:0] = s_q.wq_cnt;
                    s_d.rdata[STAT_STAR_OK_BIT] = star_ok;
                    s_d.rdata[STAT_HAVE_LAST_BIT] = s_q.have_last;
                    s_d.rdata[STAT_OVF_BIT] = s_q.ovf;
                end
                ADDR_TSTAMP: s_d.rdata = s_q.tstamp;
                ADDR_CMD, ADDR_TXDATA: s_d.rdata = '0;
                default: begin
                    s_d.rdata = '0;
                    s_d.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
            s_d.arready = 1'b1;
        end

        // edge skip counter runs only in input modes
        if (!is_in_mode(s_q.mode)) begin
            s_d.skip_cnt = '0;
        end else if (rise) begin
            s_d.skip_cnt = act ? 8'h00 : s_q.skip_cnt + 8'h01;
        end

        // frame engine handshake and write queue
        if (s_q.tx_valid && tx_ready_i) begin
            s_d.tx_valid = 1'b0;
        end
        if (!s_d.tx_valid) begin
            if (s_q.mode == TRANSMIT_ON_INPUT) begin
                if (act && s_q.wq_cnt != '0) begin
                    s_d.tx_valid = 1'b1;
                    s_d.tx_data = s_q.wq_mem[s_q.wq_rd];
                    s_d.last = s_q.wq_mem[s_q.wq_rd];
                    s_d.have_last = 1'b1;
                    s_d.wq_rd = s_q.wq_rd + 1'b1;
                    s_d.wq_cnt = s_q.wq_cnt - 1'b1;
                end else if (act && s_q.have_last) begin
                    s_d.tx_valid = 1'b1;
                    s_d.tx_data = s_q.last;
                end
            end else if (s_q.wq_cnt != '0) begin
                s_d.tx_valid = 1'b1;
                s_d.tx_data = s_q.wq_mem[s_q.wq_rd];
                s_d.last = s_q.wq_mem[s_q.wq_rd];
                s_d.have_last = 1'b1;
                s_d.wq_rd = s_q.wq_rd + 1'b1;
                s_d.wq_cnt = s_q.wq_cnt - 1'b1;
            end
        end
        if (push) begin
            if (s_q.wq_cnt < (AW+1)'(s_q.wqlen)) begin
                s_d.wq_mem[s_q.wq_wr] = s_q.wdata;
                s_d.wq_wr = s_q.wq_wr + 1'b1;
                s_d.wq_cnt = s_d.wq_cnt + 1'b1;
            end else begin
                s_d.ovf = 1'b1; // set wins over clear
            end
        end

        // timestamp frames
        s_d.rx_valid = 1'b0;
        if (act && s_q.mode == TIMESTAMP_ON_INPUT) begin
            s_d.rx_valid = 1'b1;
            s_d.rx_ts = s_q.tstamp;
            s_d.rx_data = {s_q.tag[7:0], s_q.tag[15:8], s_q.tag[23:16], s_q.tag[31:24]};
        end

        // output events; none in trigger-off or input modes
        out_ev = ((s_q.mode == OUTPUT_ON_COMMAND) && action)
              || ((s_q.mode == OUTPUT_ON_RECEIVE) && rx_stored_i)
              || ((s_q.mode == OUTPUT_ON_TRANSMIT) && tx_done_i);
        case (s_q.out_st)
            OUT_IDLE: begin
                if (out_ev && s_q.toggle) begin
                    s_d.out_lvl = !s_q.out_lvl;
                end else if (out_ev) begin
                    s_d.out_lvl = 1'b1;
                    s_d.pulse_cnt = s_q.gen1 ? 12'(PULSE_CYC_GEN1 - 1) : 12'(PULSE_CYC_GEN2 - 1);
                    s_d.out_st = OUT_PULSE;
                end
            end
            OUT_PULSE: begin
                if (out_ev && !s_q.toggle) begin
                    s_d.pulse_cnt = s_q.gen1 ? 12'(PULSE_CYC_GEN1 - 1) : 12'(PULSE_CYC_GEN2 - 1);
                end else if (s_q.pulse_cnt == '0) begin
                    s_d.out_lvl = 1'b0;
                    s_d.out_st = OUT_IDLE;
                end else begin
                    s_d.pulse_cnt = s_q.pulse_cnt - 12'h001;
                end
            end
            default: begin
                s_d.out_st = OUT_IDLE;
            end
        endcase
        if (!is_out_mode(s_q.mode)) begin
            s_d.out_st = OUT_IDLE;
            s_d.out_lvl = 1'b0;
        end
        s_d.trig = '0;
        s_d.trig_oe_n = '1;
        if (is_out_mode(s_q.mode)) begin
            s_d.trig[s_q.line] = s_d.out_lvl;
            s_d.trig_oe_n[s_q.line] = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.mode <= tsl_mode_t'(CTRL_RST[CTRL_MODE_LSB +: 3]);
            s_q.toggle <= CTRL_RST[CTRL_BEHAV_BIT];
            s_q.gen1 <= CTRL_RST[CTRL_GEN1_BIT];
            s_q.line <= CTRL_RST[CTRL_LINE_LSB +: 3];
            s_q.skip <= CTRL_RST[CTRL_SKIP_LSB +: 8];
            s_q.wqlen <= CTRL_RST[CTRL_WQLEN_LSB +: 5];
            s_q.tag <= TAG_RST;
            s_q.tb <= tsl_tb_t'(ROUTE_RST[ROUTE_TB_LSB +: 2]);
            s_q.out_st <= OUT_IDLE;
            s_q.trig_oe_n <= '1;
            s_q.awready <= 1'b1;
            s_q.wready <= 1'b1;
            s_q.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign trig_o = s_q.trig;
    assign trig_oe_n = s_q.trig_oe_n;
    assign timebase_sel_o = s_q.tb;
    assign osc_export_o = s_q.export_osc;
    assign tx_valid_o = s_q.tx_valid;
    assign tx_data_o = s_q.tx_data;
    assign rx_valid_o = s_q.rx_valid;
    assign rx_ts_o = s_q.rx_ts;
    assign rx_data_o = s_q.rx_data;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence seq_pulse_start;
        s_q.out_st == OUT_IDLE && out_ev && !s_q.toggle && is_out_mode(s_d.mode);
    endsequence

    sequence seq_short_start;
        seq_pulse_start ##0 !s_q.gen1;
    endsequence

    sequence seq_pulse_tail;
        s_q.out_lvl ##1 !s_q.out_lvl;
    endsequence

    // short pulse: high two cycles, low on the third unless a new event restarts it
    AST_PULSE_WIDTH: assert property (seq_short_start ##1 (!out_ev && is_out_mode(s_d.mode)) ##1 !out_ev
        |-> $past(s_q.out_lvl) ##0 seq_pulse_tail)
        else $error("pulse width wrong");
    AST_PULSE_SEQ: assert property (seq_pulse_start |=> s_q.out_lvl && s_q.out_st == OUT_PULSE
        && s_q.pulse_cnt == ($past(s_q.gen1) ? 12'(PULSE_CYC_GEN1 - 1) : 12'(PULSE_CYC_GEN2 - 1)))
        else $error("pulse start wrong");
    AST_PULSE_HOLD: assert property (s_q.out_st == OUT_PULSE && s_q.pulse_cnt != 12'h000
        && is_out_mode(s_q.mode) |=> s_q.out_lvl)
        else $error("pulse ended early");
    AST_TOGGLE: assert property (s_q.out_st == OUT_IDLE && out_ev && s_q.toggle
        && is_out_mode(s_d.mode) |=> s_q.out_lvl != $past(s_q.out_lvl))
        else $error("toggle did not invert");
    AST_OFF_QUIET: assert property ($past(s_q.mode) == TRIGGER_OFF |-> s_q.trig_oe_n == 7'h7F && s_q.trig == 7'h00)
        else $error("line driven while off");
    AST_LINE_RANGE: assert property (s_q.line <= LINE_MAX)
        else $error("line select out of range");
    AST_WQ_LIMIT: assert property (push && s_q.wq_cnt >= (AW+1)'(s_q.wqlen) |=> s_q.ovf && s_q.wq_cnt <= $past(s_q.wq_cnt))
        else $error("write queue over length");
    AST_TAG_ORDER: assert property (s_q.rx_valid |-> s_q.rx_data[7:0] == $past(s_q.tag[31:24])
        && s_q.rx_data[31:24] == $past(s_q.tag[7:0]))
        else $error("tag byte order wrong");
    AST_TS_MODE_ONLY: assert property (s_q.rx_valid |-> $past(s_q.mode) == TIMESTAMP_ON_INPUT && $past(act))
        else $error("timestamp outside its mode");
    AST_SKIP: assert property (rise && is_in_mode(s_q.mode) && s_q.skip_cnt < s_q.skip
        |-> !act ##1 s_q.skip_cnt == $past(s_q.skip_cnt) + 8'h01)
        else $error("edge skip miscounted");
    AST_RESEND: assert property (act && s_q.mode == TRANSMIT_ON_INPUT && s_q.wq_cnt == '0
        && s_q.have_last && (!s_q.tx_valid || tx_ready_i) |=> s_q.tx_valid && s_q.tx_data == $past(s_q.last))
        else $error("last frame not resent");
endmodule

// [hdl/tsl_pkg.sv]
/*
  tsl_pkg: register map, field positions, reset values, modes and timing
  counts for the trigger sync line block.
  assumes: aclk is the master timebase at 20 MHz; registers are 32-bit words.
*/
package tsl_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TAG = 8'h04;
    localparam logic [7:0] ADDR_ROUTE = 8'h08;
    localparam logic [7:0] ADDR_CMD = 8'h0C;
    localparam logic [7:0] ADDR_TXDATA = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_TSTAMP = 8'h18;
    // control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_BEHAV_BIT = 3;
    localparam int CTRL_GEN1_BIT = 4;
    localparam int CTRL_LINE_LSB = 8;
    localparam int CTRL_SKIP_LSB = 16;
    localparam int CTRL_WQLEN_LSB = 24;
    // routing fields
    localparam int ROUTE_TB_LSB = 0;
    localparam int ROUTE_EXPORT_BIT = 2;
    localparam int ROUTE_STAR_BIT = 3;
    // command bits
    localparam int CMD_ACTION_BIT = 0;
    localparam int CMD_CLR_OVF_BIT = 1;
    // status fields
    localparam int STAT_STAR_OK_BIT = 8;
    localparam int STAT_HAVE_LAST_BIT = 9;
    localparam int STAT_OVF_BIT = 10;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0A00_0000;
    localparam logic [31:0] TAG_RST = 32'h0000_0000;
    localparam logic [31:0] ROUTE_RST = 32'h0000_0000;
    // bus line limits
    localparam logic [2:0] LINE_MAX = 3'h6;
    localparam logic [4:0] STAR_MIN_SLOT = 5'h03;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int PULSE_NS_GEN2 = 100;
    localparam int PULSE_NS_GEN1 = 100_000;
    localparam int PULSE_CYC_GEN2 = (PULSE_NS_GEN2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYC_GEN1 = (PULSE_NS_GEN1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        TRIGGER_OFF = 3'b000,
        OUTPUT_ON_COMMAND = 3'b001,
        OUTPUT_ON_RECEIVE = 3'b010,
        OUTPUT_ON_TRANSMIT = 3'b011,
        TIMESTAMP_ON_INPUT = 3'b100,
        TRANSMIT_ON_INPUT = 3'b101
    } tsl_mode_t;

    typedef enum logic [1:0] {
        TB_LOCAL = 2'b00,
        TB_CLOCK_LINE = 2'b01,
        TB_BACKPLANE = 2'b10
    } tsl_tb_t;

    typedef enum logic {
        OUT_IDLE = 1'b0,
        OUT_PULSE = 1'b1
    } tsl_out_st_t;
endpackage

// [tb/tsl_far_card.sv]
/*
  tsl_far_card: another card on the trigger bus, making rising edges on request.
  assumes: lines are pulled low when idle; the bench calls pulses on a clock edge, and the task waits 7 ns first.
*/
`timescale 1ns/1ps
module tsl_far_card (
    // trigger bus lines
    output logic [7:0] trig
);
    initial trig = 8'h00;
    // 400 ns period edges; the clock line runs only while edges are made
    task automatic pulses(input int ln, input int n);
        #7;
        repeat (n) begin
            trig[ln] = 1'b1;
            trig[7] = 1'b1;
            #200;
            trig[ln] = 1'b0;
            trig[7] = 1'b0;
            #200;
        end
    endtask
endmodule

// [tb/tb.sv]
/*
  tb: register, trigger output, input edge and routing tests.
  assumes: tsl_pkg map; aclk 50 ns; frame engine always ready.
*/
`timescale 1ns/1ps
module tb;
    import tsl_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rv, rxd;
    logic [1:0] resp, ev;
    logic star;
    logic [4:0] slot;
    logic [31:0] ts0, ts1;
    wire [7:0] trig;
    wire awready, wready, bvalid, arready, rvalid, tx_valid, rx_valid, osc_exp;
    wire [1:0] bresp, rresp, tb_sel;
    wire [31:0] rdata, tx_data, rx_data, rx_ts;
    wire [6:0] trig_o, trig_oe_n;
    int miscompares, n_tests, rxn, hi, n;
    logic [31:0] txq[$];
    tsl_trigger_sync tsl_trigger_sync_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .trig_i(trig), .trig_o(trig_o), .trig_oe_n(trig_oe_n), .star_trig_i(star), .slot_i(slot),
        .timebase_sel_o(tb_sel), .osc_export_o(osc_exp), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
        .tx_ready_i(1'b1), .tx_done_i(ev[1]), .rx_stored_i(ev[0]), .rx_valid_o(rx_valid), .rx_ts_o(rx_ts),
        .rx_data_o(rx_data));
    tsl_far_card tsl_far_card_i (.trig(trig));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (rx_valid === 1'b1) begin
            rxn++;
            rxd = rx_data;
            ts0 = ts1;
            ts1 = rx_ts;
        end
        if (tx_valid === 1'b1) txq.push_back(tx_data);
        if (trig_o[3] === 1'b1) hi++;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1; n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 40);
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
        if (n >= 40) begin
            miscompares++;
            end_sim();
        end
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1; n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 40);
        rv = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
        if (n >= 40) begin
            miscompares++;
            end_sim();
        end
    endtask
    initial begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; ev = 2'h0; star = 1'b0; slot = 5'h00;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ADDR_CTRL); chk(rv, CTRL_RST);
        rd(ADDR_TAG); chk(rv, TAG_RST);
        rd(ADDR_ROUTE); chk(rv, ROUTE_RST);
        rd(8'h1C); chk({rv[31:2], resp}, {30'h0, RESP_SLVERR});
        wr(8'h1C, 32'h1); chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        $display("test registers done");
        hi = 0; wr(ADDR_CMD, 32'h1); repeat (8) @(posedge aclk);
        chk(hi, 0); chk({25'h0, trig_oe_n}, 32'h7F);
        wr(ADDR_CTRL, 32'h0A00_0301); hi = 0; wr(ADDR_CMD, 32'h1); repeat (8) @(posedge aclk);
        chk(hi, PULSE_CYC_GEN2);
        chk({25'h0, trig_oe_n}, 32'h77);
        wr(ADDR_CTRL, 32'h0A00_0701); rd(ADDR_CTRL); chk(rv, 32'h0A00_0301);
        for (int m = 2; m < 4; m++) begin
            wr(ADDR_CTRL, 32'h0A00_0300 | m); hi = 0;
            ev <= 2'(1 << (m - 2)); @(posedge aclk); ev <= 2'h0; repeat (8) @(posedge aclk);
            chk(hi, PULSE_CYC_GEN2);
        end
        wr(ADDR_CTRL, 32'h0A00_0311); hi = 0; wr(ADDR_CMD, 32'h1); repeat (2010) @(posedge aclk);
        chk(hi, PULSE_CYC_GEN1);
        $display("test pulse done");
        wr(ADDR_CTRL, 32'h0A00_0309); wr(ADDR_CMD, 32'h1); repeat (4) @(posedge aclk);
        chk({31'h0, trig_o[3]}, 32'h1);
        wr(ADDR_CMD, 32'h1); repeat (4) @(posedge aclk);
        chk({31'h0, trig_o[3]}, 32'h0);
        $display("test toggle done");
        wr(ADDR_TAG, 32'hAABB_CCDD); wr(ADDR_CTRL, 32'h0A01_020C); rxn = 0;
        tsl_far_card_i.pulses(2, 4); repeat (8) @(posedge aclk);
        chk(rxn, 2);
        chk(rxd, 32'hDDCC_BBAA);
        chk(ts1 - ts0, 32'h0000_0010);
        $display("test timestamp done");
        wr(ADDR_CTRL, 32'h0A00_0205); txq = {};
        wr(ADDR_TXDATA, 32'h11);
        wr(ADDR_TXDATA, 32'h22); tsl_far_card_i.pulses(2, 3); repeat (8) @(posedge aclk);
        chk({txq.size()}, 3);
        chk({8'h0, txq[0][7:0], txq[1][7:0], txq[2][7:0]}, 32'h112222);
        wr(ADDR_CTRL, 32'h0100_0205); wr(ADDR_TXDATA, 32'h33); wr(ADDR_TXDATA, 32'h44);
        rd(ADDR_STATUS); chk(rv, 32'h0000_0601);
        wr(ADDR_CMD, 32'h2); rd(ADDR_STATUS); chk(rv, 32'h0000_0201);
        $display("test transmit on edge done");
        slot <= 5'h03; repeat (3) @(posedge aclk);
        rd(ADDR_STATUS); chk(rv, 32'h0000_0301);
        wr(ADDR_ROUTE, 32'h8); wr(ADDR_CTRL, 32'h0A00_0204); rxn = 0;
        star <= 1'b1; repeat (4) @(posedge aclk); star <= 1'b0; repeat (8) @(posedge aclk);
        chk(rxn, 1);
        slot <= 5'h02; repeat (3) @(posedge aclk);
        rd(ADDR_STATUS); chk(rv, 32'h0000_0200);
        star <= 1'b1; repeat (4) @(posedge aclk); star <= 1'b0; repeat (8) @(posedge aclk);
        chk(rxn, 1);
        $display("test star trigger done");
        wr(ADDR_ROUTE, 32'h5); repeat (2) @(posedge aclk);
        chk({29'h0, osc_exp, tb_sel}, 32'h5);
        wr(ADDR_ROUTE, 32'h2); wr(ADDR_ROUTE, 32'h3); repeat (2) @(posedge aclk);
        chk({29'h0, osc_exp, tb_sel}, 32'h2);
        $display("test routing done");
        end_sim();
    end
endmodule
